// ===== include/daodt_pkg.sv
// package for the termination mode controller: map, fields, timing and bus carriers
package daodt_pkg;

  // register map (byte addresses)
  localparam logic [3:0] DAODT_CTRL_OFS   = 4'h0;
  localparam logic [3:0] DAODT_TIMING_OFS = 4'h4;
  localparam logic [3:0] DAODT_STATUS_OFS = 4'h8;

  // control fields
  localparam int DAODT_CTRL_DLLSEL_BIT = 0;
  localparam int DAODT_CTRL_NOM_BIT    = 1;
  localparam int DAODT_CTRL_WR_BIT     = 2;
  localparam int DAODT_CTRL_CWL_LSB    = 4;
  localparam int DAODT_CTRL_AL_LSB     = 8;
  localparam logic [31:0] DAODT_CTRL_RST = 32'h0000_0053;

  // timing fields: refresh cycle time and dll-locking exit delay, in clocks
  localparam int DAODT_TIM_RFC_LSB   = 0;
  localparam int DAODT_TIM_XPDLL_LSB = 8;
  localparam logic [31:0] DAODT_TIMING_RST = 32'h0000_0a40;

  // status fields
  localparam int DAODT_ST_RTT_BIT    = 0;
  localparam int DAODT_ST_ASYNC_BIT  = 1;
  localparam int DAODT_ST_ENTRY_BIT  = 2;
  localparam int DAODT_ST_EXIT_BIT   = 3;
  localparam int DAODT_ST_RESYNC_BIT = 4;
  localparam int DAODT_ST_PD_BIT     = 5;
  localparam int DAODT_ST_LEAD_LSB   = 8;
  localparam int DAODT_ST_ODTL_LSB   = 16;

  localparam logic [1:0] DAODT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DAODT_RESP_SLVERR = 2'h2;

  // timing, printed figures in picoseconds
  localparam int DAODT_CLK_PERIOD_PS = 50000;
  localparam int DAODT_AON_MIN_PS    = 2000;
  localparam int DAODT_AON_MAX_PS    = 8500;
  localparam int DAODT_AOF_MIN_PS    = 2000;
  localparam int DAODT_AOF_MAX_PS    = 8500;

  function automatic int daodt_cyc_up(input int ps);
    int c;
    c = (ps + DAODT_CLK_PERIOD_PS - 1) / DAODT_CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : daodt_cyc_up

  function automatic int daodt_cyc_dn(input int ps);
    int c;
    c = ps / DAODT_CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : daodt_cyc_dn

  localparam int DAODT_AON_MIN_CYC = daodt_cyc_up(DAODT_AON_MIN_PS);
  localparam int DAODT_AON_MAX_CYC = daodt_cyc_dn(DAODT_AON_MAX_PS);
  localparam int DAODT_AOF_MIN_CYC = daodt_cyc_up(DAODT_AOF_MIN_PS);
  localparam int DAODT_AOF_MAX_CYC = daodt_cyc_dn(DAODT_AOF_MAX_PS);
  // response point: latest legal cycle that is still not before the earliest
  localparam logic [4:0] DAODT_AON_CYC =
    5'((DAODT_AON_MAX_CYC > DAODT_AON_MIN_CYC) ? DAODT_AON_MAX_CYC : DAODT_AON_MIN_CYC);
  localparam logic [4:0] DAODT_AOF_CYC =
    5'((DAODT_AOF_MAX_CYC > DAODT_AOF_MIN_CYC) ? DAODT_AOF_MAX_CYC : DAODT_AOF_MIN_CYC);

  localparam int DAODT_DELAY_DEPTH = 32;

  function automatic logic [7:0] daodt_max8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction : daodt_max8

  typedef enum logic [3:0] {
    DAODT_SYNC  = 4'h1,
    DAODT_ENTRY = 4'h2,
    DAODT_ASYNC = 4'h4,
    DAODT_EXIT  = 4'h8
  } daodt_mode_t;

  // axi4-lite carriers
  typedef struct packed {
    logic        awvalid;
    logic [3:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [3:0]  araddr;
    logic        rready;
  } daodt_axil_m2s_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } daodt_axil_s2m_t;

endpackage : daodt_pkg

// ===== src/daodt_delay.sv
// programmable delay line for the termination enable
`timescale 1ns/10ps
`default_nettype none
module daodt_delay import daodt_pkg::*; (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // sample in, latency in clocks (1 and up)
  input  wire logic       din,
  input  wire logic [4:0] lat,
  // registered output
  output logic            dout
);

  typedef struct packed {
    logic [DAODT_DELAY_DEPTH-1:0] hist;
    logic                         out;
  } daodt_dly_t;

  daodt_dly_t st_reg;
  daodt_dly_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.hist = {st_reg.hist[DAODT_DELAY_DEPTH-2:0], din};
    // hist[0] holds last cycle's sample, so tap lat-2 yields lat clocks in total
    if (lat <= 5'h01) begin
      st_next.out = din;
    end else begin
      st_next.out = st_reg.hist[lat - 5'h02];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.out;

endmodule : daodt_delay
`default_nettype wire

// ===== src/daodt_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module daodt_sync2 import daodt_pkg::*; #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } daodt_sync_t;

  daodt_sync_t st_reg;
  daodt_sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.s2;

endmodule : daodt_sync2
`default_nettype wire

// ===== src/daodt_top.sv
// termination mode controller: sync/async odt response around precharge power-down
//
// Summary of operation
// - With termination enabled and the dll-off-in-power-down select at zero, precharge power-down runs async.
// - While the dll re-synchronises after a reset, the odt input is handled asynchronously.
// - Async mode ignores additive latency and uses the async turn-on and turn-off delays instead.
// - Async turn-on starts no earlier than 2 ns and is complete no later than 8.5 ns after odt is sampled high; here rtt_on follows odt_s by one 50 ns clock.
// - Async turn-off starts no earlier than 2 ns and reaches high impedance by 8.5 ns after odt is sampled low; here rtt_on follows odt_s by one 50 ns clock.
// - The entry transition window exists only when the dll-off-in-power-down select is zero.
// - The entry window starts the mode-switch lead before cke is first registered low and ends there; here it opens at cke low, only during a refresh.
// - The mode-switch lead equals write latency minus one clock.
// - A refresh still running at cke low stretches the entry window to the refresh cycle time after it.
// - Odt asserted in the entry window may act between the lesser minimum and greater maximum of both modes.
// - Odt deasserted in the entry window obeys the same combined bounds.
// - The exit window starts the lead before cke registered high and ends the dll exit delay after it; the code opens it only when cke is registered high.
// - Odt changes in the exit window obey the combined sync and async bounds.
// - A short cke low pulse merges entry and exit windows until the later end of both.
// - A short cke high pulse merges exit and entry windows until the end of the following entry.
// - Sync turn-on and turn-off latency both equal cas write latency plus additive latency minus two.
`timescale 1ns/10ps
`default_nettype none
module daodt_top import daodt_pkg::*; #(
  parameter int DLL_RESYNC_CYCLES = 512
) (
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // register bus
  input  wire daodt_axil_m2s_t axil_in,
  output daodt_axil_s2m_t      axil_out,
  // pins from the controller
  input  wire logic            odt_pin,
  input  wire logic            cke_pin,
  // same-clock command decode
  input  wire logic            refresh_cmd,
  input  wire logic            dll_reset,
  // termination and mode
  output logic                 rtt_on,
  output logic                 async_mode,
  output logic                 transition_window
);

  typedef struct packed {
    daodt_mode_t mode;
    logic        cke_d;
    logic [7:0]  win_cnt;
    logic [7:0]  rfc_cnt;
    logic [15:0] dll_cnt;
    logic        asy;
    logic        win;
    // bus side
    logic        aw_full;
    logic [3:0]  awaddr;
    logic        w_full;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] ctrl;
    logic [31:0] timing;
  } daodt_core_t;

  localparam logic [15:0] DLL_CNT_INIT = 16'(DLL_RESYNC_CYCLES);

  daodt_core_t st_reg;
  daodt_core_t st_next;

  logic [1:0] pins_s;
  logic       cke_s;
  logic       odt_s;
  logic       dly_out;
  logic [4:0] dly_lat;
  logic       term_en;
  logic [4:0] wl;
  logic [4:0] odtl;
  logic [4:0] lead;
  logic [7:0] rfc_val;
  logic [7:0] xpdll_val;
  logic       dll_sel;
  logic [31:0] status;
  logic        wr_go;

  daodt_sync2 #(.W(2)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   ({cke_pin, odt_pin}),
    .sync_out (pins_s)
  );

  assign cke_s = pins_s[1];
  assign odt_s = pins_s[0];

  // configuration decode
  assign dll_sel   = st_reg.ctrl[DAODT_CTRL_DLLSEL_BIT];
  assign term_en   = st_reg.ctrl[DAODT_CTRL_NOM_BIT] | st_reg.ctrl[DAODT_CTRL_WR_BIT];
  assign wl        = {1'b0, st_reg.ctrl[DAODT_CTRL_CWL_LSB +: 4]} + {1'b0, st_reg.ctrl[DAODT_CTRL_AL_LSB +: 4]};
  // a cwl plus al below two would underflow; software keeps cwl at legal values
  assign odtl      = wl - 5'h02;
  assign lead      = wl - 5'h01;
  assign rfc_val   = st_reg.timing[DAODT_TIM_RFC_LSB +: 8];
  assign xpdll_val = st_reg.timing[DAODT_TIM_XPDLL_LSB +: 8];

  // async path uses fixed analog-time delays, no additive latency
  always_comb begin
    if (st_reg.asy) begin
      dly_lat = odt_s ? DAODT_AON_CYC : DAODT_AOF_CYC;
    end else if (odtl == 5'h00) begin
      dly_lat = 5'h01;
    end else begin
      dly_lat = odtl;
    end
  end

  daodt_delay u_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (odt_s & term_en),
    .lat     (dly_lat),
    .dout    (dly_out)
  );

  assign status = {8'h00, 3'h0, odtl, 3'h0, lead, 2'h0,
                   ~st_reg.mode[0], st_reg.dll_cnt != 16'h0000,
                   st_reg.mode[3], st_reg.mode[1], st_reg.asy, dly_out};

  assign wr_go = st_reg.aw_full & st_reg.w_full & ~st_reg.bvalid;

  always_comb begin
    st_next       = st_reg;
    st_next.cke_d = cke_s;

    // refresh cycle time tracker
    if (refresh_cmd) begin
      st_next.rfc_cnt = rfc_val;
    end else if (st_reg.rfc_cnt != 8'h00) begin
      st_next.rfc_cnt = st_reg.rfc_cnt - 8'h01;
    end

    // dll re-synchronisation after reset
    if (dll_reset) begin
      st_next.dll_cnt = DLL_CNT_INIT;
    end else if (st_reg.dll_cnt != 16'h0000) begin
      st_next.dll_cnt = st_reg.dll_cnt - 16'h0001;
    end

    if (st_reg.win_cnt != 8'h00) begin
      st_next.win_cnt = st_reg.win_cnt - 8'h01;
    end

    // power-down mode tracking on registered cke edges
    case (st_reg.mode)
      DAODT_SYNC: begin
        if (st_reg.cke_d & ~cke_s & ~dll_sel) begin
          if (st_reg.rfc_cnt > 8'h01) begin
            st_next.mode = DAODT_ENTRY;
          end else begin
            st_next.mode = DAODT_ASYNC;
          end
        end
      end
      DAODT_ENTRY: begin
        if (~st_reg.cke_d & cke_s) begin
          // short low pulse: hold uncertain to the later end of both windows
          st_next.mode    = DAODT_EXIT;
          st_next.win_cnt = daodt_max8(xpdll_val, st_reg.rfc_cnt);
        end else if (st_reg.rfc_cnt <= 8'h01) begin
          st_next.mode = DAODT_ASYNC;
        end
      end
      DAODT_ASYNC: begin
        if (~st_reg.cke_d & cke_s) begin
          st_next.mode    = DAODT_EXIT;
          st_next.win_cnt = xpdll_val;
        end
      end
      DAODT_EXIT: begin
        if (st_reg.cke_d & ~cke_s) begin
          // short high pulse: stay uncertain through the next entry
          if (st_reg.rfc_cnt > 8'h01) begin
            st_next.mode = DAODT_ENTRY;
          end else begin
            st_next.mode = DAODT_ASYNC;
          end
        end else if (st_reg.win_cnt <= 8'h01) begin
          st_next.mode = DAODT_SYNC;
        end
      end
      default: begin
        st_next.mode = DAODT_SYNC;
      end
    endcase

    // async while powered down with dll off, in the exit window, or during resync;
    // inside a window either response is legal, the entry side keeps sync
    st_next.asy = term_en & ((st_next.mode == DAODT_ASYNC) | (st_next.mode == DAODT_EXIT)
                  | (st_next.dll_cnt != 16'h0000));
    st_next.win = (st_next.mode == DAODT_ENTRY) | (st_next.mode == DAODT_EXIT);

    // axi4-lite write: address and data in either order, response after both
    if (axil_in.awvalid & ~st_reg.aw_full) begin
      st_next.aw_full = 1'b1;
      st_next.awaddr  = axil_in.awaddr;
    end
    if (axil_in.wvalid & ~st_reg.w_full) begin
      st_next.w_full = 1'b1;
      st_next.wdata  = axil_in.wdata;
      st_next.wstrb  = axil_in.wstrb;
    end
    if (wr_go) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = DAODT_RESP_OKAY;
      case ({st_reg.awaddr[3:2], 2'b00})
        DAODT_CTRL_OFS: begin
          for (int i = 0; i < 4; i++) begin
            if (st_reg.wstrb[i]) begin
              st_next.ctrl[8*i +: 8] = st_reg.wdata[8*i +: 8];
            end
          end
        end
        DAODT_TIMING_OFS: begin
          for (int i = 0; i < 4; i++) begin
            if (st_reg.wstrb[i]) begin
              st_next.timing[8*i +: 8] = st_reg.wdata[8*i +: 8];
            end
          end
        end
        DAODT_STATUS_OFS: begin
          st_next.bresp = DAODT_RESP_OKAY;
        end
        default: begin
          st_next.bresp = DAODT_RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid & axil_in.bready) begin
      st_next.bvalid = 1'b0;
    end

    // axi4-lite read
    if (axil_in.arvalid & ~st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = DAODT_RESP_OKAY;
      case ({axil_in.araddr[3:2], 2'b00})
        DAODT_CTRL_OFS:   st_next.rdata = st_reg.ctrl;
        DAODT_TIMING_OFS: st_next.rdata = st_reg.timing;
        DAODT_STATUS_OFS: st_next.rdata = status;
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = DAODT_RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid & axil_in.rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg        <= '0;
      st_reg.mode   <= DAODT_SYNC;
      st_reg.ctrl   <= DAODT_CTRL_RST;
      st_reg.timing <= DAODT_TIMING_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // bus answers
  assign axil_out.awready = ~st_reg.aw_full;
  assign axil_out.wready  = ~st_reg.w_full;
  assign axil_out.bvalid  = st_reg.bvalid;
  assign axil_out.bresp   = st_reg.bresp;
  assign axil_out.arready = ~st_reg.rvalid;
  assign axil_out.rvalid  = st_reg.rvalid;
  assign axil_out.rdata   = st_reg.rdata;
  assign axil_out.rresp   = st_reg.rresp;

  assign rtt_on            = dly_out;
  assign async_mode        = st_reg.asy;
  // the controller must not lean on termination timing while this is high
  assign transition_window = st_reg.win;

endmodule : daodt_top
`default_nettype wire

// ===== testbench/daodt_bench.sv
// self-checking bench for the termination mode controller
`timescale 1ns/10ps
`default_nettype none
module daodt_bench import daodt_pkg::*;;
  typedef struct packed {
    logic        wr;
    logic [3:0]  a;
    logic [31:0] d;
    logic [3:0]  st;
    logic [31:0] exp;
    logic [1:0]  resp;
  } daodt_row_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic req_odt = 1'b0, req_cke = 1'b1, req_ref = 1'b0, req_dll = 1'b0, allow_win = 1'b0;
  logic odt_pin, cke_pin, refresh_cmd, dll_reset, rtt_on, async_mode, transition_window;
  daodt_axil_m2s_t m = '0;
  daodt_axil_s2m_t s;
  logic [31:0] rd;
  logic [1:0]  rs;
  int err_count = 0, checks_done = 0, n;
  daodt_row_t rows[12] = '{
    '{1'b0, 4'h0, 32'h0, 4'h0, 32'h0000_0053, 2'h0}, '{1'b0, 4'h4, 32'h0, 4'h0, 32'h0000_0a40, 2'h0},
    '{1'b0, 4'h8, 32'h0, 4'h0, 32'h0003_0400, 2'h0}, '{1'b1, 4'hc, 32'h1, 4'hf, 32'h0, 2'h2},
    '{1'b0, 4'hc, 32'h0, 4'h0, 32'h0, 2'h2}, '{1'b1, 4'h8, 32'hffff_ffff, 4'hf, 32'h0, 2'h0},
    '{1'b0, 4'h8, 32'h0, 4'h0, 32'h0003_0400, 2'h0}, '{1'b1, 4'h0, 32'h0000_0273, 4'hf, 32'h0, 2'h0},
    '{1'b0, 4'h8, 32'h0, 4'h0, 32'h0007_0800, 2'h0}, '{1'b1, 4'h0, 32'hffff_ff52, 4'h1, 32'h0, 2'h0},
    '{1'b0, 4'h0, 32'h0, 4'h0, 32'h0000_0252, 2'h0}, '{1'b0, 4'h8, 32'h0, 4'h0, 32'h0005_0600, 2'h0}};

  always #25 aclk = ~aclk;

  daodt_top #(.DLL_RESYNC_CYCLES(16)) u_dut (.aclk(aclk), .aresetn(aresetn), .axil_in(m), .axil_out(s),
    .odt_pin(odt_pin), .cke_pin(cke_pin), .refresh_cmd(refresh_cmd), .dll_reset(dll_reset),
    .rtt_on(rtt_on), .async_mode(async_mode), .transition_window(transition_window));
  daodt_ctl_model #(.LEAD(6)) u_ctl (.aclk(aclk), .aresetn(aresetn), .req_odt(req_odt), .req_cke(req_cke),
    .req_ref(req_ref), .req_dll(req_dll), .allow_win(allow_win), .transition_window(transition_window),
    .odt_pin(odt_pin), .cke_pin(cke_pin), .refresh_cmd(refresh_cmd), .dll_reset(dll_reset));

  task tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  // values read right after an edge are the ones sampled at that edge
  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
    m.awvalid <= 1'b1; m.awaddr <= a; m.wvalid <= 1'b1; m.wdata <= d; m.wstrb <= st; m.bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (m.awvalid && s.awready) m.awvalid <= 1'b0;
      if (m.wvalid && s.wready) m.wvalid <= 1'b0;
      // bready stays up between transfers, so the next call never drives it twice in one step
      if (s.bvalid) begin r = s.bresp; break; end
    end
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    m.arvalid <= 1'b1; m.araddr <= a; m.rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (m.arvalid && s.arready) m.arvalid <= 1'b0;
      if (s.rvalid) begin d = s.rdata; r = s.rresp; break; end
    end
  endtask : axi_rd

  // rtt must still hold the old level one edge before the expected change
  task odt_step(input logic v, input int lat);
    req_odt <= v;
    tick(lat + 1);
    check({31'h0, rtt_on}, {31'h0, ~v});
    tick(1);
    check({31'h0, rtt_on}, {31'h0, v});
  endtask : odt_step

  task measure(output int len);
    int k;
    len = 0; k = 0;
    while (!transition_window && k < 20) begin tick(1); k++; end
    while (transition_window && len < 300) begin tick(1); len++; end
  endtask : measure

  initial begin
    tick(30000);
    err_count++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    tick(16);
    aresetn <= 1'b1;
    tick(1);
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rows[i].st, rs);
      else axi_rd(rows[i].a, rd, rs);
      if (!rows[i].wr) check(rd, rows[i].exp);
      check({30'h0, rs}, {30'h0, rows[i].resp});
    end
    $display("register table done");
    odt_step(1'b1, 7); odt_step(1'b0, 7);
    tick(8); req_cke <= 1'b0; tick(10);
    check({31'h0, async_mode}, 32'h1); check({31'h0, transition_window}, 32'h0);
    odt_step(1'b1, 3); odt_step(1'b0, 3);
    req_cke <= 1'b1; measure(n);
    check(n, 32'd10); check({31'h0, async_mode}, 32'h0);
    $display("entry and exit done");
    tick(8); req_cke <= 1'b0; tick(10); allow_win <= 1'b1; req_cke <= 1'b1; tick(5);
    req_odt <= 1'b1; tick(9); check({31'h0, rtt_on}, 32'h1);
    req_odt <= 1'b0; tick(9); check({31'h0, rtt_on}, 32'h0);
    allow_win <= 1'b0; tick(20);
    req_ref <= 1'b1; tick(1); req_ref <= 1'b0; tick(3); req_cke <= 1'b0; measure(n);
    check({31'h0, n >= 50 && n <= 64}, 32'h1); check({31'h0, async_mode}, 32'h1);
    allow_win <= 1'b1; req_cke <= 1'b1; tick(3); req_cke <= 1'b0; measure(n);
    check({31'h0, n < 10}, 32'h1); check({31'h0, async_mode}, 32'h1);
    req_cke <= 1'b1; tick(30);
    req_ref <= 1'b1; tick(1); req_ref <= 1'b0; tick(3); req_cke <= 1'b0; tick(8); req_cke <= 1'b1;
    measure(n); check({31'h0, n >= 40}, 32'h1); check({31'h0, async_mode}, 32'h0);
    allow_win <= 1'b0;
    $display("refresh and short pulses done");
    axi_wr(4'h0, 32'h0000_0255, 4'hf, rs); tick(8); req_cke <= 1'b0; tick(10);
    check({31'h0, async_mode}, 32'h0); check({31'h0, transition_window}, 32'h0);
    odt_step(1'b1, 7); odt_step(1'b0, 7);
    req_cke <= 1'b1; tick(10);
    req_dll <= 1'b1; tick(1); req_dll <= 1'b0; tick(4);
    check({31'h0, async_mode}, 32'h1);
    odt_step(1'b1, 3);
    tick(20); check({31'h0, async_mode}, 32'h0);
    odt_step(1'b0, 7);
    axi_wr(4'h0, 32'h0000_0250, 4'hf, rs); req_odt <= 1'b1; tick(12);
    check({31'h0, rtt_on}, 32'h0);
    req_odt <= 1'b0;
    $display("mode select and resync done");
    aresetn <= 1'b0; tick(2); aresetn <= 1'b1; tick(1);
    axi_rd(DAODT_CTRL_OFS, rd, rs);
    check(rd, DAODT_CTRL_RST);
    $display("second reset done");
    // stalled ready: read data and write response must stand until taken
    m.rready  <= 1'b0;
    m.arvalid <= 1'b1;
    m.araddr  <= DAODT_TIMING_OFS;
    tick(1);
    m.arvalid <= 1'b0;
    tick(3);
    check({31'h0, s.rvalid}, 32'h1);
    m.rready <= 1'b1;
    tick(1);
    check(s.rdata, DAODT_TIMING_RST);
    m.bready  <= 1'b0;
    m.awvalid <= 1'b1;
    m.awaddr  <= DAODT_TIMING_OFS;
    m.wvalid  <= 1'b1;
    m.wdata   <= DAODT_TIMING_RST;
    m.wstrb   <= 4'hf;
    tick(1);
    m.awvalid <= 1'b0;
    m.wvalid  <= 1'b0;
    tick(4);
    check({31'h0, s.bvalid}, 32'h1);
    m.bready <= 1'b1;
    tick(1);
    check({30'h0, s.bresp}, {30'h0, DAODT_RESP_OKAY});
    $display("stalled ready done");
    finish_test();
  end
endmodule : daodt_bench
`default_nettype wire

// ===== testbench/daodt_ctl_model.sv
// memory controller model driving odt, cke and command strobes
`timescale 1ns/10ps
`default_nettype none
module daodt_ctl_model #(
  parameter int LEAD = 6
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // requests from the bench
  input  wire logic req_odt,
  input  wire logic req_cke,
  input  wire logic req_ref,
  input  wire logic req_dll,
  input  wire logic allow_win,
  // device state
  input  wire logic transition_window,
  // pins
  output logic      odt_pin,
  output logic      cke_pin,
  output logic      refresh_cmd,
  output logic      dll_reset
);
  int quiet;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      odt_pin     <= 1'b0;
      cke_pin     <= 1'b1;
      refresh_cmd <= 1'b0;
      dll_reset   <= 1'b0;
      quiet       <= 0;
    end else begin
      refresh_cmd <= req_ref;
      dll_reset   <= req_dll;
      // termination is undefined in a window, so odt waits unless a test forces it
      if (!transition_window || allow_win) odt_pin <= req_odt;
      quiet <= (req_odt != odt_pin) ? 0 : quiet + 1;
      // cke moves only after odt was steady for the mode-switch lead, or at once while allow_win is set
      if (quiet >= LEAD || allow_win) cke_pin <= req_cke;
    end
  end
endmodule : daodt_ctl_model
`default_nettype wire

// ===== testbench/daodt_properties.sv
// checker for the termination mode controller, bound to its top
`timescale 1ns/10ps
`default_nettype none
module daodt_properties import daodt_pkg::*; #(
  parameter int DLL_RESYNC_CYCLES = 512
) (
  // clock and reset
  input wire logic            aclk,
  input wire logic            aresetn,
  // register bus
  input wire daodt_axil_m2s_t axil_in,
  input wire daodt_axil_s2m_t axil_out,
  // pins and strobes
  input wire logic            odt_pin,
  input wire logic            cke_pin,
  input wire logic            refresh_cmd,
  input wire logic            dll_reset,
  // termination and mode
  input wire logic            rtt_on,
  input wire logic            async_mode,
  input wire logic            transition_window
);
  // dll exit delay after reset of the timing register
  localparam int XPDLL = int'(DAODT_TIMING_RST[DAODT_TIM_XPDLL_LSB +: 8]);
  logic [8:0] win_len;

  // length of the current window, saturating so a stuck window still trips the bound
  always_ff @(posedge aclk) begin
    if (!aresetn) win_len <= 9'h000;
    else if (transition_window) win_len <= (win_len == 9'h1ff) ? win_len : win_len + 9'h001;
    else win_len <= 9'h000;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  async_on_a: assert property (async_mode [*5] ##0 $past(odt_pin, 3) |-> rtt_on)
    else $error("async turn-on late");
  async_off_a: assert property (async_mode [*5] ##0 !$past(odt_pin, 3) |-> !rtt_on)
    else $error("async turn-off late");
  window_cause_a: assert property ($rose(transition_window) |-> $past(cke_pin, 3) != $past(cke_pin, 4))
    else $error("window opened without a cke edge");
  exit_len_a: assert property ($fell(transition_window) && !async_mode |-> win_len >= XPDLL)
    else $error("exit window shorter than dll exit delay");
  window_bound_a: assert property (transition_window |-> win_len < 9'd200)
    else $error("window never closes");
  write_answer_a: assert property (axil_in.awvalid && axil_out.awready && axil_in.wvalid && axil_out.wready
    |-> ##2 axil_out.bvalid)
    else $error("write response not on time");
  resp_hold_a: assert property (axil_out.bvalid && !axil_in.bready |=> axil_out.bvalid && $stable(axil_out.bresp))
    else $error("write response dropped");
  read_hold_a: assert property (axil_out.rvalid && !axil_in.rready |=> axil_out.rvalid && $stable(axil_out.rdata))
    else $error("read data dropped");
  read_answer_a: assert property (axil_in.arvalid && axil_out.arready |=> axil_out.rvalid)
    else $error("read data not on time");

  cover property (async_mode [*5] ##0 rtt_on);
  cover property ($rose(transition_window));
  cover property (axil_out.bvalid && axil_out.bresp == DAODT_RESP_SLVERR);
endmodule : daodt_properties

bind daodt_top daodt_properties #(.DLL_RESYNC_CYCLES(DLL_RESYNC_CYCLES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .axil_in(axil_in), .axil_out(axil_out), .odt_pin(odt_pin),
  .cke_pin(cke_pin), .refresh_cmd(refresh_cmd), .dll_reset(dll_reset), .rtt_on(rtt_on),
  .async_mode(async_mode), .transition_window(transition_window));
`default_nettype wire
